// ### rtl/sfsf_irq.v
// Sticky interrupt status with write-one-to-clear and a mask register.
// Assumes events are one-cycle pulses on the system clock.
`timescale 1ns/1ns
`include "sfsf_map.vh"

module sfsf_irq #(
  parameter W = `SFSF_EV_W  // Number of event bits.
) (
  input  wire         clk_i,    // System clock.
  input  wire         rst_i,    // Synchronous reset, active high.
  input  wire [W-1:0] event_i,  // Event pulses.
  input  wire [W-1:0] clr_i,    // Bits written with one.
  input  wire         mask_we_i,// Mask write strobe.
  input  wire [W-1:0] mask_i,   // New mask, lanes already merged.
  output reg  [W-1:0] status_o, // Sticky status.
  output reg  [W-1:0] mask_o,   // Mask, one enables.
  output wire         irq_o     // Level interrupt.
);

  // A set in the clearing cycle wins, so no event is lost.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_o <= {W{1'b0}};
      mask_o   <= {W{1'b0}};
    end
    else
    begin
      status_o <= (status_o & ~clr_i) | event_i;
      if (mask_we_i)
        mask_o <= mask_i;
    end
  end

  assign irq_o = |(status_o & mask_o);

endmodule // sfsf_irq

// ### rtl/sfsf_map.vh
// Constants for the FIFO status-flag block: register offsets, field
// positions, event bits, reset values and selection codes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SFSF_MAP_VH
`define SFSF_MAP_VH

// Wishbone byte addresses of the software registers.
`define SFSF_REG_STATUS   8'h00
`define SFSF_REG_IRQ_STAT 8'h04
`define SFSF_REG_IRQ_MASK 8'h08
`define SFSF_REG_OFFSETS  8'h0C

// Flag bit positions in the status register.
`define SFSF_ST_EMPTY     0
`define SFSF_ST_AEMPTY    1
`define SFSF_ST_AFULL     2
`define SFSF_ST_FULL      3
`define SFSF_ST_DUAL      4
`define SFSF_ST_CNT_LSB   16

// Offsets register: empty offset low half, full offset high half.
`define SFSF_OFS_N_LSB    0
`define SFSF_OFS_M_LSB    16

// Interrupt event bits, shared by status and mask registers.
`define SFSF_EV_EMPTY     0
`define SFSF_EV_AEMPTY    1
`define SFSF_EV_AFULL     2
`define SFSF_EV_FULL      3
`define SFSF_EV_OVFL      4
`define SFSF_EV_UDFL      5
`define SFSF_EV_W         6

// Offset register defaults after reset: seven words each.
`define SFSF_OFS_LO_DEF   8'h07
`define SFSF_OFS_HI_DEF   8'h00

// One-hot selection of the four offset byte registers.
`define SFSF_SEL_N_LO     4'h1
`define SFSF_SEL_N_HI     4'h2
`define SFSF_SEL_M_LO     4'h4
`define SFSF_SEL_M_HI     4'h8

`endif

// ### rtl/sfsf_offset_regs.v
// Four byte-wide flag offset registers with cyclic write and read selection.
// Assumes the parent qualifies the load and read strobes by mode and pins.
`timescale 1ns/1ns
`include "sfsf_map.vh"

module sfsf_offset_regs (
  input  wire        clk_i,       // System clock.
  input  wire        clr_i,       // Synchronous clear to defaults.
  input  wire        load_i,      // Write the selected offset byte.
  input  wire        read_i,      // Advance the read-back selection.
  input  wire [7:0]  data_i,      // Byte to load.
  output wire [15:0] empty_ofs_o, // Empty offset n.
  output wire [15:0] full_ofs_o,  // Full offset m.
  output reg  [7:0]  rd_byte_o    // Byte under read-back selection.
);

  localparam [3:0] S_N_LO = `SFSF_SEL_N_LO;
  localparam [3:0] S_N_HI = `SFSF_SEL_N_HI;
  localparam [3:0] S_M_LO = `SFSF_SEL_M_LO;
  localparam [3:0] S_M_HI = `SFSF_SEL_M_HI;

  reg [7:0] n_lo, n_hi, m_lo, m_hi; // Offset bytes.
  reg [3:0] wsel;                   // Write selection, one-hot.
  reg [3:0] rsel;                   // Read selection, one-hot.

  assign empty_ofs_o = {n_hi, n_lo};
  assign full_ofs_o  = {m_hi, m_lo};

  // Next selection in the fixed order, wrapping after the fourth.
  function [3:0] sel_next;
    input [3:0] s;
    begin
      case (s)
        S_N_LO:  sel_next = S_N_HI;
        S_N_HI:  sel_next = S_M_LO;
        S_M_LO:  sel_next = S_M_HI;
        default: sel_next = S_N_LO;
      endcase
    end
  endfunction

  // Read-back byte follows the read selection.
  always @*
  begin
    case (rsel)
      S_N_LO:  rd_byte_o = n_lo;
      S_N_HI:  rd_byte_o = n_hi;
      S_M_LO:  rd_byte_o = m_lo;
      default: rd_byte_o = m_hi;
    endcase
  end

  // Loads and read-backs step through the same order.
  always @(posedge clk_i)
  begin
    if (clr_i)
    begin
      n_lo <= `SFSF_OFS_LO_DEF;
      n_hi <= `SFSF_OFS_HI_DEF;
      m_lo <= `SFSF_OFS_LO_DEF;
      m_hi <= `SFSF_OFS_HI_DEF;
      wsel <= S_N_LO;
      rsel <= S_N_LO;
    end
    else
    begin
      if (load_i)
      begin
        case (wsel)
          S_N_LO:  n_lo <= data_i;
          S_N_HI:  n_hi <= data_i;
          S_M_LO:  m_lo <= data_i;
          default: m_hi <= data_i;
        endcase
        wsel <= sel_next(wsel);
      end
      if (read_i)
        rsel <= sel_next(rsel);
    end
  end

endmodule // sfsf_offset_regs

// ### rtl/sfsf_top.v
// FIFO with empty, full and programmable almost flags, offset registers,
// and a Wishbone register port with an interrupt.
// Assumes write and read sides share clk_i (clocks tied together), so the
// pointer difference needs no crossing; pins are synchronous to clk_i.
//
// Operation
// - almost-empty low at or below n
// - almost-empty high from n+1 words
// - almost-full registered, low at depth-m
// - almost-full high when free exceeds m
// - empty offset defaults to seven
// - full offset defaults to seven
// - depth 64..8192, full at depth
// - writes ignored while full
// - full flag updated on write clock
// - empty low when none; reads blocked
// - empty flag updated on read clock
// - offsets read back in write order
// - load writes next offset, wrapping
// - second write enable sampled at reset
// - reset empties FIFO, asserts empty
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "sfsf_map.vh"

module sfsf_top #(
  parameter DEPTH = 64,  // Words, power of two, 64 to 8192.
  parameter AW    = 6    // Address bits, log2 of DEPTH.
) (
  input  wire        clk_i,                 // System clock, 125 MHz.
  input  wire        rst_i,                 // Synchronous reset, high.
  input  wire        reset_n_i,             // Device reset pin, low.
  input  wire [8:0]  wr_data_i,             // Write data.
  input  wire        wr_enable_a_n_i,       // First write enable, low.
  input  wire        wr_enable_b_or_load_i, // Second enable or load_n.
  input  wire        rd_enable_a_n_i,       // First read enable, low.
  input  wire        rd_enable_b_n_i,       // Second read enable, low.
  output reg  [8:0]  rd_data_o,             // Read data or offset byte.
  output reg         empty_flag_n_o,        // Empty flag, low = empty.
  output reg         full_flag_n_o,         // Full flag, low = full.
  output reg         almost_empty_flag_n_o, // Almost empty, low.
  output reg         almost_full_flag_n_o,  // Almost full, low.
  input  wire [7:0]  wb_adr_i,              // Wishbone byte address.
  input  wire [31:0] wb_dat_i,              // Wishbone write data.
  output reg  [31:0] wb_dat_o,              // Wishbone read data.
  input  wire [3:0]  wb_sel_i,              // Wishbone byte lanes.
  input  wire        wb_we_i,               // Wishbone write.
  input  wire        wb_cyc_i,              // Wishbone cycle.
  input  wire        wb_stb_i,              // Wishbone strobe.
  output reg         wb_ack_o,              // Wishbone acknowledge.
  output wire        irq_o                  // Interrupt, high level.
);

  localparam CW = AW + 1;                    // Count width.
  localparam [CW-1:0] DEPTH_C = DEPTH;       // Depth at count width.
  localparam [15:0]   DEPTH_W = DEPTH;       // Depth for offset math.
  localparam [CW-1:0] ONE_C   = 1;           // Pointer increment.
  localparam [CW-1:0] ZERO_C  = 0;           // Empty count.
  localparam EVW = `SFSF_EV_W;               // Event count.

  // Storage and pointers; one extra pointer bit tells full from empty.
  reg  [8:0]    mem [0:DEPTH-1];             // Word storage.
  reg  [CW-1:0] wr_ptr;                      // Write pointer.
  reg  [CW-1:0] rd_ptr;                      // Read pointer.
  reg           dual_mode;                   // High: two write enables.

  // Combinational next state.
  wire          fifo_clr;                    // Either reset asserted.
  wire          load_n;                      // Load pin in flag mode.
  wire          wr_req;                      // Write attempted.
  wire          rd_req;                      // Both read enables low.
  wire          do_write;                    // Write accepted.
  wire          do_read;                     // Read accepted.
  wire          ofs_load;                    // Offset byte load.
  wire          ofs_read;                    // Offset byte read-back.
  wire [CW-1:0] next_wr_ptr;                 // Pointer after write.
  wire [CW-1:0] next_rd_ptr;                 // Pointer after read.
  wire [CW-1:0] next_count;                  // Unread words next cycle.
  wire [15:0]   count_w;                     // Count widened.
  wire [15:0]   free_w;                      // Free locations.
  wire          next_empty_n;                // Next empty flag.
  wire          next_full_n;                 // Next full flag.
  wire          next_aempty_n;               // Next almost empty.
  wire          next_afull_n;                // Next almost full.
  wire [15:0]   empty_ofs;                   // Offset n.
  wire [15:0]   full_ofs;                    // Offset m.
  wire [7:0]    ofs_byte;                    // Offset read-back byte.

  // Bus side.
  wire          bus_req;                     // Request present.
  wire          bus_wr;                      // Write taken this edge.
  wire [31:0]   lane;                        // Byte lane mask.
  wire [EVW-1:0] events;                     // Event pulses.
  wire [EVW-1:0] irq_stat;                   // Sticky status.
  wire [EVW-1:0] irq_mask;                   // Interrupt mask.
  wire [EVW-1:0] irq_clr;                    // Write-one clears.
  wire [EVW-1:0] next_mask;                  // Mask after lane merge.
  wire          mask_we;                     // Mask write strobe.
  reg  [31:0]   rd_mux;                      // Read data select.

  // Unsigned "at most" compare used by both almost flags.
  function at_most;
    input [15:0] a;
    input [15:0] b;
    begin
      at_most = (a <= b);
    end
  endfunction

  // Expand Wishbone byte selects into a bit mask.
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  assign fifo_clr = rst_i | ~reset_n_i;

  // In flag mode the second write pin is the active-low load.
  assign load_n = dual_mode | wr_enable_b_or_load_i;

  // A data write needs the second enable high in either mode.
  assign wr_req = ~wr_enable_a_n_i & wr_enable_b_or_load_i;
  assign rd_req = ~rd_enable_a_n_i & ~rd_enable_b_n_i;

  assign do_write = wr_req & full_flag_n_o & ~fifo_clr;

  assign do_read = rd_req & load_n & empty_flag_n_o & ~fifo_clr;

  // load low with first enable low
  assign ofs_load = ~load_n & ~wr_enable_a_n_i & ~fifo_clr;

  assign ofs_read = ~load_n & rd_req & ~fifo_clr;

  assign next_wr_ptr = do_write ? wr_ptr + ONE_C : wr_ptr;
  assign next_rd_ptr = do_read  ? rd_ptr + ONE_C : rd_ptr;

  assign next_count = next_wr_ptr - next_rd_ptr;
  assign count_w    = {{(16-CW){1'b0}}, next_count};
  assign free_w     = DEPTH_W - count_w;

  assign next_empty_n  = (next_count != ZERO_C);
  assign next_full_n   = (next_count != DEPTH_C);
  assign next_aempty_n = ~at_most(count_w, empty_ofs);
  assign next_afull_n  = ~at_most(free_w, full_ofs);

  // Offset registers; a device reset restores the defaults too.
  sfsf_offset_regs u_ofs (
    .clk_i       (clk_i),
    .clr_i       (fifo_clr),
    .load_i      (ofs_load),
    .read_i      (ofs_read),
    .data_i      (wr_data_i[7:0]),
    .empty_ofs_o (empty_ofs),
    .full_ofs_o  (full_ofs),
    .rd_byte_o   (ofs_byte)
  );

  // mode sampled while reset held
  // The pin is caught on every clock that reset is low, so the last
  // value before release wins; rst_i alone picks flag mode.
  always @(posedge clk_i)
  begin
    if (rst_i)
      dual_mode <= 1'b0;
    else if (~reset_n_i)
      dual_mode <= wr_enable_b_or_load_i;
  end

  // Storage write; no reset, contents are don't-care while empty.
  always @(posedge clk_i)
  begin
    if (do_write)
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
  end

  // Pointers and flags. With one clock, the write-side flags and the
  // read-side flags share the edge; each is still a single flop.
  always @(posedge clk_i)
  begin
    if (fifo_clr)
    begin
      wr_ptr                <= ZERO_C;
      rd_ptr                <= ZERO_C;
      empty_flag_n_o        <= 1'b0;
      almost_empty_flag_n_o <= 1'b0;
      full_flag_n_o         <= 1'b1;
      almost_full_flag_n_o  <= 1'b1;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      empty_flag_n_o        <= next_empty_n;
      almost_empty_flag_n_o <= next_aempty_n;
      full_flag_n_o         <= next_full_n;
      almost_full_flag_n_o  <= next_afull_n;
    end
  end

  // Output register. An empty FIFO keeps its last word; offset bytes
  // come out as the low eight bits with bit eight clear.
  always @(posedge clk_i)
  begin
    if (fifo_clr)
      rd_data_o <= 9'h000;
    else if (do_read)
      rd_data_o <= mem[rd_ptr[AW-1:0]];
    else if (ofs_read)
      rd_data_o <= {1'b0, ofs_byte};
  end

  // Event pulses on flag entry and on refused accesses.
  assign events[`SFSF_EV_EMPTY]  = empty_flag_n_o & ~next_empty_n & ~fifo_clr;
  assign events[`SFSF_EV_AEMPTY] = almost_empty_flag_n_o & ~next_aempty_n
                                   & ~fifo_clr;
  assign events[`SFSF_EV_AFULL]  = almost_full_flag_n_o & ~next_afull_n
                                   & ~fifo_clr;
  assign events[`SFSF_EV_FULL]   = full_flag_n_o & ~next_full_n & ~fifo_clr;
  assign events[`SFSF_EV_OVFL]   = wr_req & ~full_flag_n_o & ~fifo_clr;
  assign events[`SFSF_EV_UDFL]   = rd_req & load_n & ~empty_flag_n_o
                                   & ~fifo_clr;

  // Wishbone decode. A write takes effect at the edge where ack is high,
  // which is the edge the master samples it.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & wb_ack_o;
  assign lane    = lane_mask(wb_sel_i);

  assign irq_clr = (bus_wr && wb_adr_i == `SFSF_REG_IRQ_STAT)
                   ? (wb_dat_i[EVW-1:0] & lane[EVW-1:0]) : {EVW{1'b0}};
  assign mask_we = bus_wr && (wb_adr_i == `SFSF_REG_IRQ_MASK);
  assign next_mask = (irq_mask & ~lane[EVW-1:0])
                     | (wb_dat_i[EVW-1:0] & lane[EVW-1:0]);

  sfsf_irq #(
    .W (EVW)
  ) u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (events),
    .clr_i     (irq_clr),
    .mask_we_i (mask_we),
    .mask_i    (next_mask),
    .status_o  (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // Read data select; unmapped addresses read zero and still ack.
  always @*
  begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `SFSF_REG_STATUS:
      begin
        rd_mux[`SFSF_ST_EMPTY]  = ~empty_flag_n_o;
        rd_mux[`SFSF_ST_AEMPTY] = ~almost_empty_flag_n_o;
        rd_mux[`SFSF_ST_AFULL]  = ~almost_full_flag_n_o;
        rd_mux[`SFSF_ST_FULL]   = ~full_flag_n_o;
        rd_mux[`SFSF_ST_DUAL]   = dual_mode;
        rd_mux[`SFSF_ST_CNT_LSB +: CW] = wr_ptr - rd_ptr;
      end
      `SFSF_REG_IRQ_STAT:
        rd_mux[EVW-1:0] = irq_stat;
      `SFSF_REG_IRQ_MASK:
        rd_mux[EVW-1:0] = irq_mask;
      `SFSF_REG_OFFSETS:
      begin
        rd_mux[`SFSF_OFS_N_LSB +: 16] = empty_ofs;
        rd_mux[`SFSF_OFS_M_LSB +: 16] = full_ofs;
      end
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // Ack one cycle after the request, dropped in the following cycle.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o & ~wb_we_i)
        wb_dat_o <= rd_mux;
    end
  end

endmodule // sfsf_top

// ### verif/sfsf_checker.sv
// Concurrent checks on the FIFO flags, pin blocking and bus acknowledge.
// Assumes it is bound to sfsf_top and sees only that module's ports.
`timescale 1ns/1ns

module sfsf_checker (
  input wire       clk_i,                 // System clock.
  input wire       rst_i,                 // Synchronous reset, high.
  input wire       reset_n_i,             // Device reset pin, low.
  input wire       wr_enable_a_n_i,       // First write enable.
  input wire       wr_enable_b_or_load_i, // Second enable or load.
  input wire       rd_enable_a_n_i,       // First read enable.
  input wire       rd_enable_b_n_i,       // Second read enable.
  input wire [8:0] rd_data_o,             // Read data.
  input wire       empty_flag_n_o,        // Empty flag.
  input wire       full_flag_n_o,         // Full flag.
  input wire       almost_empty_flag_n_o, // Almost empty flag.
  input wire       almost_full_flag_n_o,  // Almost full flag.
  input wire       wb_cyc_i,              // Bus cycle.
  input wire       wb_stb_i,              // Bus strobe.
  input wire       wb_ack_o               // Bus acknowledge.
);
  // One clock domain, so clocking and disable are declared once.
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A word write offered on the pins outside the device reset.
  sequence s_wr_try;
    reset_n_i && !wr_enable_a_n_i && wr_enable_b_or_load_i;
  endsequence

  // A word read offered with the load pin released.
  sequence s_rd_try;
    reset_n_i && !rd_enable_a_n_i && !rd_enable_b_n_i && wr_enable_b_or_load_i;
  endsequence

  a_pin_reset_empty: assert property (
    !reset_n_i |=> !empty_flag_n_o && !almost_empty_flag_n_o && full_flag_n_o
      && almost_full_flag_n_o) else $error("Device reset left wrong flags");
  a_full_blocks_wr: assert property (
    reset_n_i && !full_flag_n_o && rd_enable_a_n_i |=> !full_flag_n_o)
    else $error("Full flag released without a read");
  a_empty_blocks_rd: assert property (
    reset_n_i && !empty_flag_n_o && wr_enable_a_n_i && wr_enable_b_or_load_i
      |=> !empty_flag_n_o && $stable(rd_data_o)) else $error("Read passed an empty store");
  a_write_leaves_empty: assert property (
    s_wr_try ##0 !empty_flag_n_o |=> empty_flag_n_o) else $error("Write kept the empty flag");
  a_read_leaves_full: assert property (
    s_rd_try ##0 (!full_flag_n_o && wr_enable_a_n_i) |=> full_flag_n_o)
    else $error("Read kept the full flag");
  a_empty_low_ae: assert property (
    !empty_flag_n_o |-> !almost_empty_flag_n_o) else $error("Almost empty high while empty");
  a_full_low_af: assert property (
    !full_flag_n_o |-> !almost_full_flag_n_o) else $error("Almost full high while full");
  a_ae_rise_cause: assert property (
    $rose(almost_empty_flag_n_o) |-> empty_flag_n_o && !$past(wr_enable_a_n_i))
    else $error("Almost empty rose without a write");
  a_af_rise_cause: assert property (
    $rose(almost_full_flag_n_o) |-> !$past(rd_enable_a_n_i) || !$past(reset_n_i))
    else $error("Almost full rose without a read");
  a_ack_one_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus acknowledge late or too long");
endmodule // sfsf_checker

// ### verif/sfsf_host_model.sv
// Writer and reader logic that turns bench requests into FIFO control pins.
// Assumes requests change right after a clock edge and hold for a cycle.
`timescale 1ns/1ns

module sfsf_host_model (
  input  wire reset_n_i,             // Device reset pin, low.
  input  wire dual_i,                // Mode to present during reset.
  input  wire wr_i,                  // Write or offset load request.
  input  wire rd_i,                  // Read or offset read request.
  input  wire load_i,                // Steer requests to the offsets.
  output wire wr_enable_a_n_o,       // First write enable, low.
  output wire wr_enable_b_or_load_o, // Second enable or load.
  output wire rd_enable_a_n_o,       // First read enable, low.
  output wire rd_enable_b_n_o        // Second read enable, low.
);
  assign wr_enable_a_n_o = ~(wr_i & reset_n_i);
  assign rd_enable_a_n_o = ~(rd_i & reset_n_i);
  assign rd_enable_b_n_o = ~(rd_i & reset_n_i);
  assign wr_enable_b_or_load_o = dual_i | (reset_n_i & ~load_i);
endmodule // sfsf_host_model

// ### verif/sfsf_top_tb.sv
// Self-checking bench for the FIFO flag block against a queue model.
// Assumes the host model on the FIFO pins and Wishbone driven here.
`timescale 1ns/1ns
`include "sfsf_map.vh"

module sfsf_top_tb;
  localparam int D = 64;          // Depth under test.
  logic        clk_i;             // System clock.
  logic        rst_i;             // Bus-side reset.
  logic        reset_n_i;         // Device reset pin.
  logic        wr_q;              // Write request.
  logic        rd_q;              // Read request.
  logic        ld_q;              // Offset access request.
  logic        dual_q;            // Mode chosen at reset.
  logic [8:0]  wr_data_i;         // Write data.
  logic [7:0]  wb_adr_i;          // Bus address.
  logic [31:0] wb_dat_i;          // Bus write data.
  logic        wb_we_i;           // Bus direction.
  logic        wb_cyc_i;          // Bus cycle.
  logic        wb_stb_i;          // Bus strobe.
  wire         wen_a;             // Pins from the host model.
  wire         wen_b;
  wire         ren_a;
  wire         ren_b;
  wire  [8:0]  rd_data_o;         // Design read data.
  wire         ef;                // Design flags, active low.
  wire         ff;
  wire         aef;
  wire         aff;
  wire         ack;               // Bus acknowledge.
  wire         irq;               // Interrupt level.
  wire  [31:0] wb_dat_o;          // Bus read data.
  int          bad_count;         // Mismatches.
  int          comparisons;       // Comparisons made.
  int          seed;              // Random seed.
  int          n;                 // Model empty offset.
  int          m;                 // Model full offset.
  int          wp;                // Model load selection.
  int          rp;                // Model read-back selection.
  logic [8:0]  q[$];              // Model store.
  logic [8:0]  exp_rd;            // Expected read data.
  logic [7:0]  ofs[4];            // Model offset bytes.
  logic [31:0] r;                 // Last bus read or random word.
  logic [7:0]  prog[5] = '{8'h03, 8'h00, 8'h05, 8'h00, 8'h02};

  sfsf_top #(.DEPTH(D), .AW(6)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .wr_data_i(wr_data_i),
    .wr_enable_a_n_i(wen_a), .wr_enable_b_or_load_i(wen_b), .rd_enable_a_n_i(ren_a),
    .rd_enable_b_n_i(ren_b), .rd_data_o(rd_data_o), .empty_flag_n_o(ef), .full_flag_n_o(ff),
    .almost_empty_flag_n_o(aef), .almost_full_flag_n_o(aff), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(4'hF), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(ack), .irq_o(irq));

  sfsf_host_model host (.reset_n_i(reset_n_i), .dual_i(dual_q), .wr_i(wr_q), .rd_i(rd_q),
    .load_i(ld_q), .wr_enable_a_n_o(wen_a), .wr_enable_b_or_load_o(wen_b),
    .rd_enable_a_n_o(ren_a), .rd_enable_b_n_o(ren_b));

  // Free-running 125 MHz clock.
  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  // Compare one result, count it and report a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Print the verdict and end the run.
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Flags the model expects from its word count and offsets.
  function automatic logic [3:0] flags_exp();
    int c;
    c = q.size();
    return {c != D, (D - c) > m, c > n, c != 0};
  endfunction

  // Back to defaults, as either reset leaves the device.
  task automatic clear_model();
    q.delete();
    exp_rd = 9'h000;
    ofs = '{8'h07, 8'h00, 8'h07, 8'h00};
    n = 7;
    m = 7;
    wp = 0;
    rp = 0;
  endtask

  // One pin cycle; the previous cycle's result is checked at mid-cycle,
  // so operations can run back to back.
  task automatic op(input logic w, input logic rr, input logic ld, input logic [8:0] d);
    logic wr_ok;
    wr_q <= w;
    rd_q <= rr;
    ld_q <= ld;
    wr_data_i <= d;
    @(negedge clk_i);
    check({28'h0, ff, aff, aef, ef}, {28'h0, flags_exp()});
    check({23'h0, rd_data_o}, {23'h0, exp_rd});
    @(posedge clk_i);
    if (ld && !dual_q)
    begin
      if (w)
      begin
        ofs[wp] = d[7:0];
        wp = (wp + 1) % 4;
      end
      else if (rr)
      begin
        exp_rd = {1'h0, ofs[rp]};
        rp = (rp + 1) % 4;
      end
      n = int'({ofs[1], ofs[0]});
      m = int'({ofs[3], ofs[2]});
    end
    else
    begin
      wr_ok = w && q.size() < D;
      if (rr && q.size() > 0)
        exp_rd = q.pop_front();
      if (wr_ok)
        q.push_back(d);
    end
  endtask

  // Classic single Wishbone cycle; read data lands in r.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20 && ack !== 1'h1; i++)
      @(posedge clk_i);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (ack !== 1'h1)
    begin
      bad_count++;
      report_and_stop();
    end
    @(posedge clk_i);
  endtask

  // Pulse the device reset pin, presenting the chosen mode.
  task automatic pin_reset(input logic dm);
    reset_n_i <= 1'h0;
    dual_q <= dm;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'h1;
    clear_model();
  endtask

  // Main sequence: defaults, fill, interrupts, drain, offsets, modes.
  initial
  begin
    seed = 18;
    bad_count = 0;
    comparisons = 0;
    rst_i = 1'h1;
    reset_n_i = 1'h1;
    wr_q = 1'h0;
    rd_q = 1'h0;
    ld_q = 1'h0;
    dual_q = 1'h0;
    wr_data_i = 9'h000;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_we_i = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    clear_model();
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, `SFSF_REG_OFFSETS, 32'h0);
    check(r, 32'h0007_0007);
    // Overfill by two so writes meet the full flag.
    repeat (D + 2) op(1'h1, 1'h0, 1'h0, 9'($random(seed)));
    op(1'h0, 1'h0, 1'h0, 9'h000);
    wb(1'h0, `SFSF_REG_STATUS, 32'h0);
    check({25'h0, r[22:16]}, D);
    wb(1'h1, `SFSF_REG_IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    wb(1'h0, `SFSF_REG_IRQ_STAT, 32'h0);
    check(r & 32'h30, 32'h10);
    wb(1'h1, `SFSF_REG_IRQ_MASK, 32'h10);
    check({31'h0, irq}, 32'h1);
    wb(1'h1, `SFSF_REG_IRQ_STAT, 32'h10);
    check({31'h0, irq}, 32'h0);
    wb(1'h0, 8'h40, 32'hFFFF_FFFF);
    check(r, 32'h0);
    // Drain one past empty so a read meets the empty flag.
    repeat (D + 1) op(1'h0, 1'h1, 1'h0, 9'h000);
    op(1'h0, 1'h0, 1'h0, 9'h000);
    wb(1'h0, `SFSF_REG_IRQ_STAT, 32'h0);
    check(r & 32'h30, 32'h20);
    // Five loads: the fifth wraps onto the empty offset low byte.
    foreach (prog[i]) op(1'h1, 1'h0, 1'h1, {1'h0, prog[i]});
    op(1'h0, 1'h0, 1'h0, 9'h000);
    wb(1'h0, `SFSF_REG_OFFSETS, 32'h0);
    check(r, 32'h0005_0002);
    repeat (4) op(1'h0, 1'h1, 1'h1, 9'h000);
    repeat (48)
    begin
      r = $random(seed);
      op(r[0] | r[1], r[2], 1'h0, r[11:3]);
    end
    pin_reset(1'h1);
    op(1'h1, 1'h0, 1'h1, 9'h1A5);
    op(1'h0, 1'h0, 1'h0, 9'h000);
    wb(1'h0, `SFSF_REG_STATUS, 32'h0);
    check({31'h0, r[4]}, 32'h1);
    check({25'h0, r[22:16]}, 32'h1);
    pin_reset(1'h0);
    op(1'h0, 1'h0, 1'h0, 9'h000);
    wb(1'h0, `SFSF_REG_OFFSETS, 32'h0);
    check(r, 32'h0007_0007);
    report_and_stop();
  end
endmodule // sfsf_top_tb

bind sfsf_top sfsf_checker chk (.clk_i, .rst_i, .reset_n_i, .wr_enable_a_n_i,
  .wr_enable_b_or_load_i, .rd_enable_a_n_i, .rd_enable_b_n_i, .rd_data_o, .empty_flag_n_o,
  .full_flag_n_o, .almost_empty_flag_n_o, .almost_full_flag_n_o, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o);
